//--- rtl/pmc_cmd_map.sv
`timescale 1ns/1ps
// Operation
// - code 01h read/write byte picks on, off or margin high/low.
// - code 02h byte sets how pin and commands switch output; reset 17h.
// - send-byte 15h saves all working settings to user storage, no data.
// - send-byte 16h reloads working settings from user storage.
// - code 20h reads fixed 13h, linear format exponent -13.
// - code 21h word is nominal output target, default from strap.
// - code 23h signed word offsets the target; reset zero.
// - code 24h word caps the target; default 110% of strap.
// - codes 25h/26h margin targets, 105%/95% of strap, used in margin.
// - output slews at rate in code 27h, except that turn-off with code 02h bit 0 set jumps straight to zero; reset BA00h.
// - code 28h load-line slope applied; reset zero.
// - code 33h word is switching frequency, default from strap.
// - code 37h phase offset, default from bus address.
// - code 38h is current-sense resistance; reset B29Ah.
// - code 39h offset subtracted from current measurement; reset zero.
module pmc_cmd_map
  import pmc_pkg::*;
#(
  parameter int TICK = TICK_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_cmd_valid,
  input wire pmc_pkg::pmc_kind_t i_cmd_kind,
  input wire logic [7:0] i_cmd_code,
  input wire logic [15:0] i_cmd_data,
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_data,
  output logic o_rsp_err,
  input wire logic i_en_pin,
  input wire logic [15:0] i_strap_vout,
  input wire logic [15:0] i_strap_freq,
  input wire logic [6:0] i_bus_addr,
  input wire logic [15:0] i_vout_meas,
  input wire logic [15:0] i_iout_raw,
  output logic o_out_on,
  output logic [15:0] o_vout_level,
  output logic [15:0] o_droop,
  output logic [15:0] o_freq,
  output logic [15:0] o_phase,
  output logic [15:0] o_cs_gain,
  output logic [15:0] o_iout_corr,
  output logic o_ov_fault,
  output logic o_ov_warn,
  output logic o_uv_warn,
  output logic o_uv_fault,
  output logic o_cml_err
);
  localparam int IX_RUN = 0;
  localparam int IX_TON = 1;
  localparam int IX_VTGT = 2;
  localparam int IX_VTRIM = 3;
  localparam int IX_VCEIL = 4;
  localparam int IX_MH = 5;
  localparam int IX_ML = 6;
  localparam int IX_SLEW = 7;
  localparam int IX_DROOP = 8;
  localparam int IX_FREQ = 9;
  localparam int IX_PHASE = 10;
  localparam int IX_CSR = 11;
  localparam int IX_CST = 12;
  localparam int IX_OVF = 13;
  localparam int IX_ACT = 14;
  localparam int IX_OVW = 15;
  localparam int IX_UVW = 16;
  localparam int IX_UVF = 17;

  initial begin
    if (TICK < 1) $error("pmc_cmd_map: TICK must be at least 1");
  end

  // code to storage slot; byte tells a byte-wide command
  function automatic logic [IXW+1:0] slot_of(input logic [7:0] c);
    logic [IXW+1:0] r;
    r = '0;
    unique case (c)
      C_RUN_MODE: r = {2'b11, IXW'(IX_RUN)};
      C_TURN_ON:  r = {2'b11, IXW'(IX_TON)};
      C_VTARGET:  r = {2'b10, IXW'(IX_VTGT)};
      C_VTRIM:    r = {2'b10, IXW'(IX_VTRIM)};
      C_VCEIL:    r = {2'b10, IXW'(IX_VCEIL)};
      C_MRG_HI:   r = {2'b10, IXW'(IX_MH)};
      C_MRG_LO:   r = {2'b10, IXW'(IX_ML)};
      C_SLEW:     r = {2'b10, IXW'(IX_SLEW)};
      C_LOADLINE: r = {2'b10, IXW'(IX_DROOP)};
      C_SWRATE:   r = {2'b10, IXW'(IX_FREQ)};
      C_PHASE:    r = {2'b10, IXW'(IX_PHASE)};
      C_CS_RES:   r = {2'b10, IXW'(IX_CSR)};
      C_CS_TRIM:  r = {2'b10, IXW'(IX_CST)};
      C_OVF_LVL:  r = {2'b10, IXW'(IX_OVF)};
      C_OVF_ACT:  r = {2'b11, IXW'(IX_ACT)};
      C_OVW_LVL:  r = {2'b10, IXW'(IX_OVW)};
      C_UVW_LVL:  r = {2'b10, IXW'(IX_UVW)};
      C_UVF_LVL:  r = {2'b10, IXW'(IX_UVF)};
      default:    r = '0;
    endcase
    return r;
  endfunction

  // power-up value of a slot; strap-derived where no fixed value exists
  function automatic logic [15:0] dflt_of(input int ix,
                                          input logic [15:0] vs,
                                          input logic [15:0] fs,
                                          input logic [6:0] ad);
    logic [15:0] r;
    r = RST_ZERO;
    unique case (ix)
      IX_RUN:   r = RST_RUN_MODE;
      IX_TON:   r = RST_TURN_ON;
      IX_VTGT:  r = vs;
      IX_VCEIL: r = pct_of(vs, PCT_CEIL);
      IX_MH:    r = pct_of(vs, PCT_MH);
      IX_ML:    r = pct_of(vs, PCT_ML);
      IX_SLEW:  r = RST_SLEW;
      IX_FREQ:  r = fs;
      IX_PHASE: r = {12'h000, ad[PHASE_W-1:0]};
      IX_CSR:   r = RST_CS_RES;
      IX_OVF:   r = pct_of(vs, PCT_OVF);
      IX_ACT:   r = RST_OVF_ACT;
      IX_OVW:   r = pct_of(vs, PCT_OVW);
      IX_UVW:   r = pct_of(vs, PCT_UVW);
      IX_UVF:   r = pct_of(vs, PCT_UVF);
      default:  r = RST_ZERO;
    endcase
    return r;
  endfunction

  logic [15:0] cfg_ff [NCFG];
  logic [15:0] user_ff [NCFG];
  logic init_ff;
  logic [IXW+1:0] slot;
  logic [IXW-1:0] ix;
  logic hit;
  logic is_byte;
  logic wr_ok;
  logic rd_ok;
  logic do_clear;
  logic do_save;
  logic do_reload;
  logic cmd_bad;

  assign slot = slot_of(i_cmd_code);
  assign hit = slot[IXW+1];
  assign is_byte = slot[IXW];
  assign ix = slot[IXW-1:0];
  assign wr_ok = i_cmd_valid && hit &&
    ((i_cmd_kind == PMC_WR_BYTE && is_byte) ||
     (i_cmd_kind == PMC_WR_WORD && !is_byte));
  assign rd_ok = i_cmd_valid && i_cmd_kind == PMC_READ &&
    (hit || i_cmd_code == C_VFORMAT);
  assign do_clear = i_cmd_valid && i_cmd_kind == PMC_SEND &&
    i_cmd_code == C_FAULT_CLR;
  assign do_save = i_cmd_valid && i_cmd_kind == PMC_SEND &&
    i_cmd_code == C_SAVE;
  assign do_reload = i_cmd_valid && i_cmd_kind == PMC_SEND &&
    i_cmd_code == C_RELOAD;
  // anything not served is dropped and reported
  assign cmd_bad = i_cmd_valid &&
    !(wr_ok || rd_ok || do_clear || do_save || do_reload);

  // straps are caught on the first enabled edge after reset release
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      init_ff <= 1'b0;
    end else if (i_ce) begin
      init_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < NCFG; k++) cfg_ff[k] <= RST_ZERO;
    end else if (i_ce) begin
      if (!init_ff) begin
        for (int k = 0; k < NCFG; k++)
          cfg_ff[k] <= dflt_of(k, i_strap_vout, i_strap_freq, i_bus_addr);
      end else if (do_reload) begin
        for (int k = 0; k < NCFG; k++) cfg_ff[k] <= user_ff[k];
      end else if (wr_ok) begin
        cfg_ff[ix] <= is_byte ? (i_cmd_data & BYTE_MASK) : i_cmd_data;
      end
    end
  end

  // user level starts equal to the power-up settings; no retention here
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < NCFG; k++) user_ff[k] <= RST_ZERO;
    end else if (i_ce) begin
      if (!init_ff) begin
        for (int k = 0; k < NCFG; k++)
          user_ff[k] <= dflt_of(k, i_strap_vout, i_strap_freq, i_bus_addr);
      end else if (do_save) begin
        for (int k = 0; k < NCFG; k++) user_ff[k] <= cfg_ff[k];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rsp_valid <= 1'b0;
      o_rsp_err <= 1'b0;
      o_rsp_data <= RST_ZERO;
    end else if (i_ce) begin
      o_rsp_valid <= i_cmd_valid;
      o_rsp_err <= cmd_bad;
      if (rd_ok) begin
        o_rsp_data <= hit ? cfg_ff[ix] : RST_VFORMAT;
      end else if (i_cmd_valid) begin
        o_rsp_data <= RST_ZERO;
      end
    end
  end

  // on/off decision
  logic [7:0] run_b;
  logic [7:0] ton_b;
  logic [7:0] act_b;
  logic pin_on;
  logic want_on;
  logic shut_ff;
  logic out_on;
  logic ovf_c;
  logic ovw_c;
  logic uvw_c;
  logic uvf_c;

  assign run_b = cfg_ff[IX_RUN][7:0];
  assign ton_b = cfg_ff[IX_TON][7:0];
  assign act_b = cfg_ff[IX_ACT][7:0];
  assign pin_on = i_en_pin ^ ~ton_b[OC_POL];
  assign want_on = init_ff && (!ton_b[OC_PU] ||
    ((!ton_b[OC_CMD] || run_b[OP_ON]) &&
     (!ton_b[OC_PIN] || pin_on)));
  assign out_on = want_on && !shut_ff;

  // fault shutdown holds until cleared or the output is re-requested
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shut_ff <= 1'b0;
      o_out_on <= 1'b0;
    end else if (i_ce) begin
      o_out_on <= out_on;
      if (ovf_c && (act_b[ACT_HI] || act_b[ACT_LO])) begin
        shut_ff <= 1'b1;
      end else if (do_clear || !want_on) begin
        shut_ff <= 1'b0;
      end
    end
  end

  // target: margin choice, plus signed trim, capped at the ceiling
  logic [15:0] base;
  logic [16:0] trimmed;
  logic [15:0] capped;
  logic [15:0] goal;
  logic [15:0] step;
  logic [4:0] sexp;
  logic [10:0] smant;

  assign base = (run_b[OP_MRG_HI] && !run_b[OP_MRG_LO]) ? cfg_ff[IX_MH] :
    (run_b[OP_MRG_LO] && !run_b[OP_MRG_HI]) ? cfg_ff[IX_ML] :
    cfg_ff[IX_VTGT];

  assign trimmed = {1'b0, base} +
    {cfg_ff[IX_VTRIM][15], cfg_ff[IX_VTRIM]};
  always_comb begin
    capped = trimmed[15:0];
    // the carry means overflow on a positive trim, underflow on a negative
    if (trimmed[16]) begin
      capped = cfg_ff[IX_VTRIM][15] ? RST_ZERO : cfg_ff[IX_VCEIL];
    end
    if (capped > cfg_ff[IX_VCEIL]) begin
      capped = cfg_ff[IX_VCEIL];
    end
  end
  assign goal = out_on ? capped : RST_ZERO;

  // rate in V/ms times 8 approximates output LSB per microsecond
  assign sexp = cfg_ff[IX_SLEW][15:11];
  assign smant = cfg_ff[IX_SLEW][10:0];
  always_comb begin
    logic [31:0] w;
    w = {21'h0, smant} << 3;
    if (sexp[4]) begin
      w = w >> (5'd0 - sexp);
    end else begin
      w = w << sexp;
    end
    step = (w == 32'h0) ? 16'h0001 :
           (|w[31:16]) ? 16'hffff : w[15:0];
  end

  pmc_ramp #(
    .TICK(TICK)
  ) u_ramp (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_goal(goal),
    .i_step(step),
    .i_jump(!out_on && ton_b[OC_FAST]),
    .o_level_ff(o_vout_level)
  );

  pmc_limit_cmp u_cmp (
    .i_level(i_vout_meas),
    .i_ovf_lvl(cfg_ff[IX_OVF]),
    .i_ovw_lvl(cfg_ff[IX_OVW]),
    .i_uvw_lvl(cfg_ff[IX_UVW]),
    .i_uvf_lvl(cfg_ff[IX_UVF]),
    .i_under_en(out_on),
    .o_ovf(ovf_c),
    .o_ovw(ovw_c),
    .o_uvw(uvw_c),
    .o_uvf(uvf_c)
  );

  // live condition beats a clear in the same cycle; limits are still zero
  // on the cycle that loads defaults, so flags wait for it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ov_fault <= 1'b0;
      o_ov_warn <= 1'b0;
      o_uv_warn <= 1'b0;
      o_uv_fault <= 1'b0;
      o_cml_err <= 1'b0;
    end else if (i_ce && init_ff) begin
      o_ov_fault <= ovf_c || (o_ov_fault && !do_clear);
      o_ov_warn <= ovw_c || (o_ov_warn && !do_clear);
      o_uv_warn <= uvw_c || (o_uv_warn && !do_clear);
      o_uv_fault <= uvf_c || (o_uv_fault && !do_clear);
      o_cml_err <= cmd_bad || (o_cml_err && !do_clear);
    end
  end

  // settings handed to the analog loop and current monitor
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_droop <= RST_ZERO;
      o_freq <= RST_ZERO;
      o_phase <= RST_ZERO;
      o_cs_gain <= RST_ZERO;
      o_iout_corr <= RST_ZERO;
    end else if (i_ce) begin
      o_droop <= cfg_ff[IX_DROOP];
      o_freq <= cfg_ff[IX_FREQ];
      o_phase <= cfg_ff[IX_PHASE];
      o_cs_gain <= cfg_ff[IX_CSR];
      o_iout_corr <= i_iout_raw - cfg_ff[IX_CST];
    end
  end
endmodule

//--- shared/pmc_pkg.sv
package pmc_pkg;
  localparam int DW = 16;
  localparam int NCFG = 18;
  localparam int IXW = 5;

  typedef enum logic [1:0] {
    PMC_SEND    = 2'b00,
    PMC_WR_BYTE = 2'b01,
    PMC_WR_WORD = 2'b10,
    PMC_READ    = 2'b11
  } pmc_kind_t;

  // command codes
  localparam logic [7:0] C_RUN_MODE = 8'h01;
  localparam logic [7:0] C_TURN_ON = 8'h02;
  localparam logic [7:0] C_FAULT_CLR = 8'h03;
  localparam logic [7:0] C_SAVE = 8'h15;
  localparam logic [7:0] C_RELOAD = 8'h16;
  localparam logic [7:0] C_VFORMAT = 8'h20;
  localparam logic [7:0] C_VTARGET = 8'h21;
  localparam logic [7:0] C_VTRIM = 8'h23;
  localparam logic [7:0] C_VCEIL = 8'h24;
  localparam logic [7:0] C_MRG_HI = 8'h25;
  localparam logic [7:0] C_MRG_LO = 8'h26;
  localparam logic [7:0] C_SLEW = 8'h27;
  localparam logic [7:0] C_LOADLINE = 8'h28;
  localparam logic [7:0] C_SWRATE = 8'h33;
  localparam logic [7:0] C_PHASE = 8'h37;
  localparam logic [7:0] C_CS_RES = 8'h38;
  localparam logic [7:0] C_CS_TRIM = 8'h39;
  localparam logic [7:0] C_OVF_LVL = 8'h40;
  localparam logic [7:0] C_OVF_ACT = 8'h41;
  localparam logic [7:0] C_OVW_LVL = 8'h42;
  localparam logic [7:0] C_UVW_LVL = 8'h43;
  localparam logic [7:0] C_UVF_LVL = 8'h44;

  // reset values
  localparam logic [15:0] RST_RUN_MODE = 16'h0000;
  localparam logic [15:0] RST_TURN_ON = 16'h0017;
  localparam logic [15:0] RST_VFORMAT = 16'h0013;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_SLEW = 16'hba00;
  localparam logic [15:0] RST_CS_RES = 16'hb29a;
  localparam logic [15:0] RST_OVF_ACT = 16'h0080;
  localparam logic [15:0] BYTE_MASK = 16'h00ff;

  // strap scaling in percent
  localparam logic [7:0] PCT_CEIL = 8'd110;
  localparam logic [7:0] PCT_MH = 8'd105;
  localparam logic [7:0] PCT_ML = 8'd95;
  localparam logic [7:0] PCT_OVF = 8'd115;
  localparam logic [7:0] PCT_OVW = 8'd110;
  localparam logic [7:0] PCT_UVW = 8'd90;
  localparam logic [7:0] PCT_UVF = 8'd85;
  localparam logic [31:0] PCT_DEN = 32'd100;

  // field positions
  localparam int OP_ON = 7;
  localparam int OP_MRG_HI = 5;
  localparam int OP_MRG_LO = 4;
  localparam int OC_PU = 4;
  localparam int OC_CMD = 3;
  localparam int OC_PIN = 2;
  localparam int OC_POL = 1;
  localparam int OC_FAST = 0;
  localparam int ACT_HI = 7;
  localparam int ACT_LO = 6;
  localparam int PHASE_W = 4;

  // slew tick: one step per microsecond
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;

  function automatic logic [15:0] pct_of(input logic [15:0] v,
                                         input logic [7:0] p);
    logic [31:0] prod;
    prod = ({16'h0000, v} * {24'h000000, p}) / PCT_DEN;
    return prod[15:0];
  endfunction
endpackage

//--- rtl/pmc_limit_cmp.sv
`timescale 1ns/1ps
module pmc_limit_cmp (
  input wire logic [15:0] i_level,
  input wire logic [15:0] i_ovf_lvl,
  input wire logic [15:0] i_ovw_lvl,
  input wire logic [15:0] i_uvw_lvl,
  input wire logic [15:0] i_uvf_lvl,
  input wire logic i_under_en,
  output logic o_ovf,
  output logic o_ovw,
  output logic o_uvw,
  output logic o_uvf
);
  // under-voltage only counts while the output is meant to be up
  assign o_ovf = i_level > i_ovf_lvl;
  assign o_ovw = i_level > i_ovw_lvl;
  assign o_uvw = i_under_en && (i_level < i_uvw_lvl);
  assign o_uvf = i_under_en && (i_level < i_uvf_lvl);
endmodule

//--- rtl/pmc_ramp.sv
`timescale 1ns/1ps
module pmc_ramp
  import pmc_pkg::*;
#(
  parameter int TICK = TICK_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [15:0] i_goal,
  input wire logic [15:0] i_step,
  input wire logic i_jump,
  output logic [15:0] o_level_ff
);
  localparam int TW = $clog2(TICK + 1);
  logic [TW-1:0] tick_ff;
  logic tick;

  initial begin
    if (TICK < 1) $error("pmc_ramp: TICK must be at least 1");
  end

  assign tick = (tick_ff == TW'(TICK - 1));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_ff <= '0;
    end else if (i_ce) begin
      tick_ff <= tick ? '0 : tick_ff + TW'(1);
    end
  end

  // step clipped so the level never overshoots the goal
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_level_ff <= RST_ZERO;
    end else if (i_ce) begin
      if (i_jump) begin
        o_level_ff <= i_goal;
      end else if (tick && o_level_ff < i_goal) begin
        o_level_ff <= (i_goal - o_level_ff > i_step) ?
                      o_level_ff + i_step : i_goal;
      end else if (tick && o_level_ff > i_goal) begin
        o_level_ff <= (o_level_ff - i_goal > i_step) ?
                      o_level_ff - i_step : i_goal;
      end
    end
  end
endmodule

//--- bench/pmc_cmd_map_asserts.sv
`timescale 1ns/1ps
module pmc_cmd_map_asserts
  import pmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_cmd_valid,
  input wire pmc_pkg::pmc_kind_t i_cmd_kind,
  input wire logic [7:0] i_cmd_code,
  input wire logic o_rsp_valid,
  input wire logic [15:0] o_rsp_data,
  input wire logic o_rsp_err,
  input wire logic o_out_on,
  input wire logic o_ov_fault,
  input wire logic o_uv_warn,
  input wire logic o_uv_fault,
  input wire logic o_cml_err
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic take;
  logic clr;
  logic fmt;
  assign take = i_cmd_valid && i_ce;
  assign clr = take && i_cmd_kind == PMC_SEND && i_cmd_code == C_FAULT_CLR;
  assign fmt = take && i_cmd_code == C_VFORMAT;

  a_cmd_answered: assert property (take |=> o_rsp_valid)
    else $error("command left without answer");
  a_rsp_cause: assert property (o_rsp_valid |-> $past(take))
    else $error("answer without command");
  a_err_in_rsp: assert property (o_rsp_err |-> o_rsp_valid)
    else $error("error outside answer");
  a_format_ro: assert property (
    fmt && i_cmd_kind != PMC_READ |=> o_rsp_err ##[0:1] o_cml_err)
    else $error("write to format code not refused");
  a_format_read: assert property (
    fmt && i_cmd_kind == PMC_READ |=> !o_rsp_err && o_rsp_data == 16'h0013)
    else $error("format code read wrong");
  a_ovf_sticky: assert property (o_ov_fault && !clr |=> o_ov_fault)
    else $error("overvoltage fault dropped");
  a_ovf_off: assert property ($rose(o_ov_fault) |-> ##[0:2] !o_out_on)
    else $error("output kept on after overvoltage fault");
  a_uvf_sticky: assert property (o_uv_fault && !clr |=> o_uv_fault)
    else $error("undervoltage fault dropped");
  a_uvw_gated: assert property (
    $rose(o_uv_warn) |-> o_out_on)
    else $error("undervoltage warning while off");
endmodule

bind pmc_cmd_map pmc_cmd_map_asserts u_chk (.i_clk, .i_rst, .i_ce,
  .i_cmd_valid, .i_cmd_kind, .i_cmd_code, .o_rsp_valid, .o_rsp_data,
  .o_rsp_err, .o_out_on, .o_ov_fault, .o_uv_warn, .o_uv_fault, .o_cml_err);

//--- bench/pmc_host_model.sv
`timescale 1ns/1ps
module pmc_host_model
  import pmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rsp_valid,
  input wire logic [15:0] i_rsp_data,
  input wire logic i_rsp_err,
  output logic o_cmd_valid,
  output pmc_pkg::pmc_kind_t o_cmd_kind,
  output logic [7:0] o_cmd_code,
  output logic [15:0] o_cmd_data
);
  logic timed_out;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_kind = PMC_READ;
    o_cmd_code = 8'h00;
    o_cmd_data = 16'h0000;
    timed_out = 1'b0;
  end
  task automatic xfer(input pmc_kind_t k, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] rd,
                      output logic er);
    int n;
    n = 0;
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    o_cmd_kind <= k;
    o_cmd_code <= c;
    o_cmd_data <= (k == PMC_SEND) ? 16'h0000 : d;
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    // data lines stop showing the old word once released
    o_cmd_data <= ~d;
    #1;
    while (!i_rsp_valid && n < 4) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    timed_out = !i_rsp_valid;
    rd = i_rsp_data;
    er = i_rsp_err;
  endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
  import pmc_pkg::*;
  logic clk, rst, ce, en_pin, cv, rv, re, on, ovf, ovw, uvw, uvf, cml, er;
  logic [15:0] sv, sf, vmeas, iraw, cd, rdd, lvl, droop, freq, phase;
  logic [15:0] gain, icorr, rd;
  logic [6:0] addr;
  logic [7:0] cc;
  pmc_kind_t ck;
  int n_fail = 0;
  int samples_checked = 0;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  pmc_cmd_map #(.TICK(1)) dut (.i_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_cmd_valid(cv), .i_cmd_kind(ck), .i_cmd_code(cc), .i_cmd_data(cd),
    .o_rsp_valid(rv), .o_rsp_data(rdd), .o_rsp_err(re), .i_en_pin(en_pin),
    .i_strap_vout(sv), .i_strap_freq(sf), .i_bus_addr(addr),
    .i_vout_meas(vmeas), .i_iout_raw(iraw), .o_out_on(on),
    .o_vout_level(lvl), .o_droop(droop), .o_freq(freq), .o_phase(phase),
    .o_cs_gain(gain), .o_iout_corr(icorr), .o_ov_fault(ovf),
    .o_ov_warn(ovw), .o_uv_warn(uvw), .o_uv_fault(uvf), .o_cml_err(cml));
  pmc_host_model host (.i_clk(clk), .i_rsp_valid(rv), .i_rsp_data(rdd),
    .i_rsp_err(re), .o_cmd_valid(cv), .o_cmd_kind(ck), .o_cmd_code(cc),
    .o_cmd_data(cd));

  task automatic finish_test();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", w, e, g);
    end
  endtask
  task automatic cmd(input pmc_kind_t k, input logic [7:0] c,
                     input logic [15:0] d);
    host.xfer(k, c, d, rd, er);
    if (host.timed_out) begin
      n_fail++;
      $display("unexpected rsp_valid exp 1 got 0");
      finish_test();
    end
  endtask
  function automatic logic [15:0] pc(input logic [7:0] p);
    return 16'((32'(sv) * 32'(p)) / 100);
  endfunction
  task automatic wait_lvl(input logic [15:0] e);
    int n;
    n = 0;
    while (lvl !== e && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("vout_level", e, lvl);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_defaults();
    logic [7:0] c [19];
    logic [15:0] e [19];
    c = '{8'h01, 8'h02, 8'h20, 8'h21, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
          8'h28, 8'h33, 8'h37, 8'h38, 8'h39, 8'h40, 8'h41, 8'h42, 8'h43,
          8'h44};
    e = '{16'h0000, 16'h0017, 16'h0013, sv, 16'h0000, pc(110), pc(105),
          pc(95), 16'hba00, 16'h0000, sf, {12'h000, addr[3:0]}, 16'hb29a,
          16'h0000, pc(115), 16'h0080, pc(110), pc(90), pc(85)};
    for (int i = 0; i < 19; i++) begin
      cmd(PMC_READ, c[i], 16'h0000);
      chk($sformatf("code %h", c[i]), e[i], rd);
    end
    chk("gain", 16'hb29a, gain);
    chk("phase", {12'h000, addr[3:0]}, phase);
    chk("ov flags", 16'h0000, {14'h0, ovf, ovw});
  endtask

  task automatic t_regs();
    iraw <= 16'h0100;
    cmd(PMC_WR_WORD, 8'h39, 16'h0010);
    cmd(PMC_WR_WORD, 8'h28, 16'h1234);
    cmd(PMC_WR_WORD, 8'h33, 16'h0321);
    cmd(PMC_WR_WORD, 8'h37, 16'h0005);
    cmd(PMC_WR_WORD, 8'h38, 16'hb300);
    tick(1);
    chk("iout_corr", 16'h00f0, icorr);
    chk("droop", 16'h1234, droop);
    chk("freq", 16'h0321, freq);
    chk("phase", 16'h0005, phase);
    chk("gain", 16'hb300, gain);
    cmd(PMC_WR_BYTE, 8'h41, 16'hffc0);
    cmd(PMC_READ, 8'h41, 16'h0000);
    chk("ov_action", 16'h00c0, rd);
    cmd(PMC_WR_WORD, 8'h20, 16'h0055);
    chk("err ro", 16'h0001, 16'(er));
    cmd(PMC_READ, 8'h20, 16'h0000);
    chk("format", 16'h0013, rd);
    cmd(PMC_WR_BYTE, 8'h21, 16'h0001);
    chk("err width", 16'h0001, 16'(er));
    cmd(PMC_WR_WORD, 8'h22, 16'h0001);
    chk("err code", 16'h0001, 16'(er));
    chk("cml_err", 16'h0001, 16'(cml));
  endtask

  task automatic t_store();
    cmd(PMC_WR_WORD, 8'h21, 16'h0f00);
    cmd(PMC_SEND, 8'h15, 16'h0000);
    cmd(PMC_WR_WORD, 8'h21, 16'h0e00);
    cmd(PMC_SEND, 8'h16, 16'h0000);
    cmd(PMC_READ, 8'h21, 16'h0000);
    chk("restored", 16'h0f00, rd);
  endtask

  task automatic t_ramp();
    logic [15:0] l0;
    cmd(PMC_WR_WORD, 8'h21, 16'h1000);
    en_pin <= 1'b1;
    wait_lvl(16'h1000);
    cmd(PMC_WR_WORD, 8'h23, 16'h0010);
    wait_lvl(16'h1010);
    cmd(PMC_WR_WORD, 8'h23, 16'hfff0);
    wait_lvl(16'h0ff0);
    cmd(PMC_WR_WORD, 8'h23, 16'h0010);
    wait_lvl(16'h1010);
    cmd(PMC_WR_BYTE, 8'h01, 16'h00a0);
    wait_lvl(pc(105) + 16'h0010);
    cmd(PMC_WR_BYTE, 8'h01, 16'h0090);
    wait_lvl(pc(95) + 16'h0010);
    cmd(PMC_WR_BYTE, 8'h01, 16'h0080);
    cmd(PMC_WR_WORD, 8'h21, 16'h2000);
    wait_lvl(pc(110));
    cmd(PMC_WR_WORD, 8'h21, 16'h1000);
    tick(1);
    l0 = lvl;
    tick(1);
    chk("slew step", l0 - 16'h0008, lvl);
    ce <= 1'b0;
    tick(3);
    chk("frozen level", l0 - 16'h0008, lvl);
    ce <= 1'b1;
    wait_lvl(16'h1010);
    en_pin <= 1'b0;
    tick(3);
    chk("off level", 16'h0000, lvl);
    chk("out_on", 16'h0000, 16'(on));
    en_pin <= 1'b1;
    wait_lvl(16'h1010);
    cmd(PMC_WR_BYTE, 8'h02, 16'h001f);
    cmd(PMC_WR_BYTE, 8'h01, 16'h0000);
    tick(2);
    chk("cmd off", 16'h0000, 16'(on));
    cmd(PMC_WR_BYTE, 8'h01, 16'h0080);
    wait_lvl(16'h1010);
  endtask

  task automatic t_faults();
    vmeas <= pc(115) + 16'h0001;
    tick(3);
    chk("ov_fault", 16'h0001, 16'(ovf));
    chk("ov_warn", 16'h0001, 16'(ovw));
    chk("out_on", 16'h0000, 16'(on));
    vmeas <= 16'h1010;
    tick(2);
    cmd(PMC_SEND, 8'h03, 16'h0000);
    chk("ov_fault", 16'h0000, 16'(ovf));
    tick(2);
    chk("out_on", 16'h0001, 16'(on));
    vmeas <= pc(85) - 16'h0001;
    tick(3);
    chk("uv_warn", 16'h0001, 16'(uvw));
    chk("uv_fault", 16'h0001, 16'(uvf));
    cmd(PMC_SEND, 8'h03, 16'h0000);
    chk("uv_fault", 16'h0001, 16'(uvf));
    vmeas <= 16'h1010;
    tick(2);
    cmd(PMC_SEND, 8'h03, 16'h0000);
    chk("uv_warn", 16'h0000, 16'(uvw));
    chk("cml_err", 16'h0000, 16'(cml));
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    en_pin = 1'b0;
    sv = 16'h1000;
    sf = 16'h0190;
    addr = 7'h2b;
    vmeas = 16'h1000;
    iraw = 16'h0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    t_defaults();
    t_regs();
    t_store();
    t_ramp();
    t_faults();
    finish_test();
  end
endmodule
